// ### core/msi_vpd_capability_regs.sv
/*
  Capability register bank of one switch port: message-signalled interrupt
  structure on downstream ports, product-data table access on the upstream
  port, vendor header on both. Registers sit on an AHB-Lite slave.
  Assumes the EEPROM side answers each access with a one-cycle done pulse,
  that the role strap only changes while reset is held, and that the bus
  master issues single whole-word transfers; hsize is not decoded.
*/
module msi_vpd_capability_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Port role strap: high for the upstream port
  input  wire logic        isUpstream,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Interrupt event source and outputs
  input  wire logic        serviceEvent,
  output logic             legacyIntPin,
  output logic             msgWriteValid,
  output logic      [63:0] msgWriteAddr,
  output logic      [15:0] msgWriteData,
  input  wire logic        msgWriteReady,
  output logic             irq,
  // EEPROM table port
  output logic             tableReq,
  output logic             tableWrite,
  output logic      [5:0]  tableIndex,
  output logic      [31:0] tableWdata,
  input  wire logic        tableDone,
  input  wire logic [31:0] tableRdata
);

  // ---------------------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------------------
  logic        wrPend_q, wrPend_d;
  logic [7:0]  wrAddr_q, wrAddr_d;
  logic [31:0] rdata_d;

  logic addrPhase;
  assign addrPhase = hsel & htrans[1] & hready;

  function automatic logic [7:0] wordOffset(input logic [31:0] a);
    wordOffset = {a[7:2], 2'b00};
  endfunction

  // A write is remembered for one cycle so that its data phase can land it.
  always_comb begin
    wrPend_d = addrPhase & hwrite;
    wrAddr_d = wrAddr_q;
    if (addrPhase) begin
      wrAddr_d = wordOffset(haddr);
    end
  end

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  // Message registers keep their flops on both roles; the role strap only
  // hides them from the bus, which keeps one netlist for every port.
  logic        msgEnable_q, msgEnable_d;
  logic [2:0]  multiEnable_q, multiEnable_d;
  logic [29:0] msgAddr_q, msgAddr_d;
  logic [31:0] msgUpper_q, msgUpper_d;
  logic [15:0] msgPayload_q, msgPayload_d;
  logic [5:0]  index_q, index_d;
  logic        permit_q, permit_d;
  logic        dirDone_q, dirDone_d;
  logic        busy_q, busy_d;
  logic [31:0] value_q, value_d;
  logic [2:0]  irqStatus_q, irqStatus_d;
  logic [2:0]  irqEnable_q, irqEnable_d;
  logic        msgPending_q, msgPending_d;
  logic        tableReq_d;
  logic        tableWrite_d;
  logic [31:0] tableWdata_d;

  logic        ctrlWrite;
  logic [2:0]  irqEvents;
  logic [2:0]  irqClear;

  // Read mux: unmapped or absent-by-role registers read as zero.
  always_comb begin
    rdata_d = msi_vpd_pkg::ResetZero;
    if (!isUpstream && wordOffset(haddr) == msi_vpd_pkg::OffMsgControl) begin
      rdata_d[7:0]   = msi_vpd_pkg::MsgCapId;
      rdata_d[15:8]  = msi_vpd_pkg::NextToVendor;
      rdata_d[msi_vpd_pkg::MsgEnableBit] = msgEnable_q;
      rdata_d[msi_vpd_pkg::MultiEnableLo +: 3] = multiEnable_q;
      rdata_d[msi_vpd_pkg::Addr64Bit] = 1'b1;
    end else if (!isUpstream && wordOffset(haddr) == msi_vpd_pkg::OffMsgAddress) begin
      rdata_d = {msgAddr_q, 2'b00};
    end else if (!isUpstream && wordOffset(haddr) == msi_vpd_pkg::OffMsgUpper) begin
      rdata_d = msgUpper_q;
    end else if (!isUpstream && wordOffset(haddr) == msi_vpd_pkg::OffMsgPayload) begin
      rdata_d[15:0] = msgPayload_q;
    end else if (isUpstream && wordOffset(haddr) == msi_vpd_pkg::OffProductCtrl) begin
      rdata_d[7:0]  = msi_vpd_pkg::ProductCapId;
      rdata_d[15:8] = msi_vpd_pkg::NextToVendor;
      rdata_d[msi_vpd_pkg::IndexLo +: 6] = index_q;
      rdata_d[msi_vpd_pkg::WritePermitBit] = permit_q;
      rdata_d[msi_vpd_pkg::DirDoneBit] = dirDone_q;
    end else if (isUpstream && wordOffset(haddr) == msi_vpd_pkg::OffProductValue) begin
      rdata_d = value_q;
    end else if (wordOffset(haddr) == msi_vpd_pkg::OffVendorHeader) begin
      rdata_d[7:0]   = msi_vpd_pkg::VendorCapId;
      rdata_d[15:8]  = msi_vpd_pkg::NextFromVend;
      rdata_d[31:16] = msi_vpd_pkg::VendorLength;
    end else if (wordOffset(haddr) == msi_vpd_pkg::OffIrqStatus) begin
      rdata_d[2:0] = irqStatus_q;
    end else if (wordOffset(haddr) == msi_vpd_pkg::OffIrqEnable) begin
      rdata_d[2:0] = irqEnable_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes and table sequencing
  // ---------------------------------------------------------------------------
  assign ctrlWrite = wrPend_q & isUpstream & (wrAddr_q == msi_vpd_pkg::OffProductCtrl);

  always_comb begin
    msgEnable_d   = msgEnable_q;
    multiEnable_d = multiEnable_q;
    msgAddr_d     = msgAddr_q;
    msgUpper_d    = msgUpper_q;
    msgPayload_d  = msgPayload_q;
    index_d       = index_q;
    permit_d      = permit_q;
    dirDone_d     = dirDone_q;
    busy_d        = busy_q;
    value_d       = value_q;
    irqEnable_d   = irqEnable_q;
    tableReq_d    = 1'b0;
    tableWrite_d  = tableWrite;
    tableWdata_d  = tableWdata;
    irqEvents     = 3'b000;
    irqClear      = 3'b000;
    if (wrPend_q) begin
      if (!isUpstream && wrAddr_q == msi_vpd_pkg::OffMsgControl) begin
        msgEnable_d   = hwdata[msi_vpd_pkg::MsgEnableBit];
        multiEnable_d = hwdata[msi_vpd_pkg::MultiEnableLo +: 3];
      end else if (!isUpstream && wrAddr_q == msi_vpd_pkg::OffMsgAddress) begin
        msgAddr_d = hwdata[31:2];
      end else if (!isUpstream && wrAddr_q == msi_vpd_pkg::OffMsgUpper) begin
        msgUpper_d = hwdata;
      end else if (!isUpstream && wrAddr_q == msi_vpd_pkg::OffMsgPayload) begin
        msgPayload_d = hwdata[15:0];
      end else if (isUpstream && wrAddr_q == msi_vpd_pkg::OffProductValue) begin
        value_d = hwdata;
      end else if (wrAddr_q == msi_vpd_pkg::OffIrqEnable) begin
        irqEnable_d = hwdata[2:0];
      end else if (wrAddr_q == msi_vpd_pkg::OffIrqClear) begin
        irqClear = hwdata[2:0];
      end
    end
    // A control write while a cycle runs is ignored; software must poll first.
    if (ctrlWrite && !busy_q) begin
      index_d  = hwdata[msi_vpd_pkg::IndexLo +: 6];
      permit_d = hwdata[msi_vpd_pkg::WritePermitBit];
      dirDone_d = hwdata[msi_vpd_pkg::DirDoneBit];
      if (hwdata[msi_vpd_pkg::DirDoneBit] && !hwdata[msi_vpd_pkg::WritePermitBit]) begin
        dirDone_d = 1'b0;
        irqEvents[msi_vpd_pkg::IrqWriteDeny] = 1'b1;
      end else begin
        // Data to write is taken from the data register at the start, so a
        // later data write cannot change a cycle already in flight.
        busy_d       = 1'b1;
        tableReq_d   = 1'b1;
        tableWrite_d = hwdata[msi_vpd_pkg::DirDoneBit];
        tableWdata_d = value_q;
      end
    end
    // Completion flips the direction flag and raises a status event in the
    // same cycle, so polling software and the interrupt line agree.
    if (busy_q && tableDone) begin
      busy_d = 1'b0;
      if (tableWrite) begin
        dirDone_d = 1'b0;
        irqEvents[msi_vpd_pkg::IrqWriteDone] = 1'b1;
      end else begin
        dirDone_d = 1'b1;
        value_d   = tableRdata;
        irqEvents[msi_vpd_pkg::IrqReadDone] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------------------
  // Set wins over clear so no completion is lost.
  always_comb begin
    irqStatus_d = (irqStatus_q & ~irqClear) | irqEvents;
  end

  // ---------------------------------------------------------------------------
  // Message-signalled interrupt request
  // ---------------------------------------------------------------------------
  logic        msgValid_d;
  logic [63:0] msgAddrOut_d;
  logic        legacy_d;

  always_comb begin
    msgPending_d = msgPending_q;
    msgValid_d   = msgWriteValid;
    msgAddrOut_d = msgWriteAddr;
    legacy_d     = 1'b0;
    if (msgWriteValid && msgWriteReady) begin
      msgValid_d = 1'b0;
    end
    if (!isUpstream && msgEnable_q) begin
      if (serviceEvent) begin
        msgPending_d = 1'b1;
      end
      // Events arriving while a write waits are merged into one pending
      // request, as a single message already tells software to look.
      if (msgPending_q && !msgValid_d) begin
        msgValid_d   = 1'b1;
        msgPending_d = serviceEvent;
        // Upper half is always placed in the address; a zero upper register gives an address in the low 32 bits.
        msgAddrOut_d = {msgUpper_q, msgAddr_q, 2'b00};
      end
    end else begin
      // Disabled or upstream: the pin echoes each event one cycle later and
      // any half-formed message is dropped rather than sent late.
      msgPending_d = 1'b0;
      legacy_d     = serviceEvent;
    end
  end

  // ---------------------------------------------------------------------------
  // Output next values
  // ---------------------------------------------------------------------------
  logic [31:0] hrdata_d;
  logic        irq_d;

  // Read data is captured in the address phase and then held, so it stands
  // through the data phase whatever the address lines do meanwhile.
  always_comb begin
    hrdata_d = hrdata;
    if (addrPhase) begin
      hrdata_d = rdata_d;
    end
    irq_d = |(irqStatus_d & irqEnable_d);
  end

  // ---------------------------------------------------------------------------
  // Bus state registers
  // ---------------------------------------------------------------------------
  // The slave never stalls and never errors, so ready and response are
  // constants held in flops only to keep every output registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      hrdata    <= msi_vpd_pkg::ResetZero;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_q  <= wrPend_d;
      wrAddr_q  <= wrAddr_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Message capability registers
  // ---------------------------------------------------------------------------
  // These hold software settings only; the request logic reads them live,
  // so a change takes effect on the next event.
  always_ff @(posedge clk) begin
    if (rst) begin
      msgEnable_q   <= 1'b0;
      multiEnable_q <= 3'h0;
      msgAddr_q     <= 30'h0000_0000;
      msgUpper_q    <= msi_vpd_pkg::ResetZero;
      msgPayload_q  <= 16'h0000;
    end else begin
      msgEnable_q   <= msgEnable_d;
      multiEnable_q <= multiEnable_d;
      msgAddr_q     <= msgAddr_d;
      msgUpper_q    <= msgUpper_d;
      msgPayload_q  <= msgPayload_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Table registers and port
  // ---------------------------------------------------------------------------
  // The index goes out from its next value so that it leaves together with
  // the request pulse rather than one cycle behind it.
  always_ff @(posedge clk) begin
    if (rst) begin
      index_q    <= 6'h00;
      permit_q   <= 1'b0;
      dirDone_q  <= 1'b0;
      busy_q     <= 1'b0;
      value_q    <= msi_vpd_pkg::ResetZero;
      tableReq   <= 1'b0;
      tableWrite <= 1'b0;
      tableIndex <= 6'h00;
      tableWdata <= msi_vpd_pkg::ResetZero;
    end else begin
      index_q    <= index_d;
      permit_q   <= permit_d;
      dirDone_q  <= dirDone_d;
      busy_q     <= busy_d;
      value_q    <= value_d;
      tableReq   <= tableReq_d;
      tableWrite <= tableWrite_d;
      tableIndex <= index_d;
      tableWdata <= tableWdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt registers
  // ---------------------------------------------------------------------------
  // The line is built from next values so it rises with the status bit
  // instead of trailing it by a cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus_q <= 3'h0;
      irqEnable_q <= 3'h0;
      irq         <= 1'b0;
    end else begin
      irqStatus_q <= irqStatus_d;
      irqEnable_q <= irqEnable_d;
      irq         <= irq_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Message request registers
  // ---------------------------------------------------------------------------
  // Payload follows the data register; software must not rewrite it while
  // a request is still waiting for acceptance.
  always_ff @(posedge clk) begin
    if (rst) begin
      msgPending_q  <= 1'b0;
      msgWriteValid <= 1'b0;
      msgWriteAddr  <= 64'h0000_0000_0000_0000;
      msgWriteData  <= 16'h0000;
      legacyIntPin  <= 1'b0;
    end else begin
      msgPending_q  <= msgPending_d;
      msgWriteValid <= msgValid_d;
      msgWriteAddr  <= msgAddrOut_d;
      msgWriteData  <= msgPayload_q;
      legacyIntPin  <= legacy_d;
    end
  end

endmodule

// ### shared/msi_vpd_pkg.sv
/*
  Constants shared by the capability register bank of one switch port:
  register byte offsets, field positions, reset values and fixed header codes.
  Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
*/
// Behaviour
// - Message enable gates messages versus legacy pin
// - Sixty-four-bit capable bit reads one
// - Message address bits 31:2 writable, reset zero
// - Upper address writable, used when 64-bit capable
// - Message registers only on downstream ports
// - Product header returns 03h, next 64h
// - Six-bit field selects table DWORD, reset zero
// - Write permit bit needed for table writes
// - Writing 0 starts read; 1 when done
// - Writing 1 starts write; 0 when done
// - Data register returns last fetched table word
// - Written data stored to selected table word
// - Product data registers only on upstream port
// - Vendor header returns 09h, next B0h
// - Vendor length field reads 34h
// - Message header returns 05h, next 64h
package msi_vpd_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OffMsgControl   = 8'h4c;
  localparam logic [7:0] OffMsgAddress   = 8'h50;
  localparam logic [7:0] OffMsgUpper     = 8'h54;
  localparam logic [7:0] OffMsgPayload   = 8'h58;
  localparam logic [7:0] OffProductCtrl  = 8'h5c;
  localparam logic [7:0] OffProductValue = 8'h60;
  localparam logic [7:0] OffVendorHeader = 8'h64;
  localparam logic [7:0] OffIrqStatus    = 8'h80;
  localparam logic [7:0] OffIrqEnable    = 8'h84;
  localparam logic [7:0] OffIrqClear     = 8'h88;

  // ---------------------------------------------------------------------------
  // Field positions and fixed codes
  // ---------------------------------------------------------------------------
  localparam int MsgEnableBit    = 16;
  localparam int MultiEnableLo   = 20;
  localparam int Addr64Bit       = 23;
  localparam int IndexLo         = 18;
  localparam int WritePermitBit  = 30;
  localparam int DirDoneBit      = 31;
  localparam logic [7:0]  MsgCapId     = 8'h05;
  localparam logic [7:0]  ProductCapId = 8'h03;
  localparam logic [7:0]  VendorCapId  = 8'h09;
  localparam logic [7:0]  NextToVendor = 8'h64;
  localparam logic [7:0]  NextFromVend = 8'hb0;
  localparam logic [15:0] VendorLength = 16'h0034;

  // ---------------------------------------------------------------------------
  // Reset values, table size and interrupt bits
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ResetZero    = 32'h0000_0000;
  localparam int          TableWords   = 64;
  localparam int          IrqReadDone  = 0;
  localparam int          IrqWriteDone = 1;
  localparam int          IrqWriteDeny = 2;

endpackage

// ### bench/eeprom_table_model.sv
/*
  Behavioural serial EEPROM holding the 64-word product data table.
  Assumes one request pulse at a time; answers alternately fast and slow.
*/
module eeprom_table_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Table port
  input  wire logic        tableReq,
  input  wire logic        tableWrite,
  input  wire logic [5:0]  tableIndex,
  input  wire logic [31:0] tableWdata,
  output logic             tableDone,
  output logic      [31:0] tableRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [31:0] wd;
  logic [5:0]  idx;
  logic        busy;
  logic        wr;
  int          waitQ;
  int          reqCount;
  initial begin
    tableDone = 1'b0;
    tableRdata = 32'h0;
    for (int i = 0; i < 64; i++) mem[i] = 32'hc0de_0000 + i;
  end
  // The read bus toggles between answers so stale data never looks valid.
  always @(posedge clk) begin
    tableDone <= 1'b0;
    tableRdata <= ~tableRdata;
    if (rst) begin
      busy <= 1'b0;
      reqCount <= 0;
    end else if (tableReq && !busy) begin
      busy <= 1'b1;
      wr <= tableWrite;
      idx <= tableIndex;
      wd <= tableWdata;
      waitQ <= reqCount[0] ? 6 : 1;
      reqCount <= reqCount + 1;
    end else if (busy && waitQ > 1) begin
      waitQ <= waitQ - 1;
    end else if (busy) begin
      busy <= 1'b0;
      tableDone <= 1'b1;
      if (wr) mem[idx] <= wd;
      else tableRdata <= mem[idx];
    end
  end
endmodule

// ### bench/msi_vpd_capability_regs_sva.sv
/*
  Checker for the capability register bank, bound to its top ports.
  Assumes one clock with a synchronous active-high reset.
*/
module msi_vpd_capability_regs_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Watched ports
  input wire logic        isUpstream,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        serviceEvent,
  input wire logic        legacyIntPin,
  input wire logic        msgWriteValid,
  input wire logic [63:0] msgWriteAddr,
  input wire logic [15:0] msgWriteData,
  input wire logic        msgWriteReady,
  input wire logic        tableReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rdPh;
  assign rdPh = hsel & htrans[1] & hready & ~hwrite;
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_legacy_cause: assert property (legacyIntPin |-> $past(serviceEvent))
    else $error("legacy pin without event");
  a_legacy_off: assert property (msgWriteValid |-> !legacyIntPin)
    else $error("legacy pin during message");
  a_msg_delay: assert property ($rose(msgWriteValid) |-> $past(serviceEvent, 2))
    else $error("message write without event");
  a_msg_hold: assert property (msgWriteValid && !msgWriteReady |=>
    msgWriteValid && $stable(msgWriteAddr) && $stable(msgWriteData))
    else $error("message write dropped or changed");
  a_msg_aligned: assert property (msgWriteValid |-> msgWriteAddr[1:0] == 2'h0)
    else $error("message address not aligned");
  a_up_no_msg: assert property (isUpstream |-> !msgWriteValid)
    else $error("message write on upstream port");
  a_req_pulse: assert property (tableReq |=> !tableReq)
    else $error("table request longer than one cycle");
  a_vendor_hdr: assert property (rdPh && haddr == 32'h64 |=>
    hrdata == 32'h0034_b009)
    else $error("vendor header wrong");
  a_product_hdr: assert property (rdPh && isUpstream && haddr == 32'h5c |=>
    hrdata[15:0] == 16'h6403)
    else $error("product header wrong");
  a_message_hdr: assert property (rdPh && !isUpstream && haddr == 32'h4c |=>
    hrdata[23] && hrdata[19:17] == 3'h0 && hrdata[15:0] == 16'h6405)
    else $error("message header wrong");
endmodule
bind msi_vpd_capability_regs msi_vpd_capability_regs_sva u_sva (
  .clk(clk), .rst(rst), .isUpstream(isUpstream), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .serviceEvent(serviceEvent),
  .legacyIntPin(legacyIntPin), .msgWriteValid(msgWriteValid),
  .msgWriteAddr(msgWriteAddr), .msgWriteData(msgWriteData),
  .msgWriteReady(msgWriteReady), .tableReq(tableReq)
);

// ### bench/msi_vpd_capability_regs_tb.sv
/*
  Self-checking bench for the capability register bank and its EEPROM.
  Assumes the checker is bound to the design and the 100 MHz clock.
*/
module msi_vpd_capability_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, isUpstream, hsel, hwrite, hready, hreadyout, hresp;
  logic        serviceEvent, legacyIntPin, msgWriteValid, msgWriteReady, irq;
  logic        tableReq, tableWrite, tableDone;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  tableIndex;
  logic [15:0] msgWriteData;
  logic [31:0] haddr, hwdata, hrdata, tableWdata, tableRdata;
  logic [63:0] msgWriteAddr;
  int          fail_count, num_checks;
  assign hready = hreadyout;
  msi_vpd_capability_regs u_dut (.clk(clk), .rst(rst), .isUpstream(isUpstream),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serviceEvent(serviceEvent), .legacyIntPin(legacyIntPin),
    .msgWriteValid(msgWriteValid), .msgWriteAddr(msgWriteAddr),
    .msgWriteData(msgWriteData), .msgWriteReady(msgWriteReady), .irq(irq),
    .tableReq(tableReq), .tableWrite(tableWrite), .tableIndex(tableIndex),
    .tableWdata(tableWdata), .tableDone(tableDone), .tableRdata(tableRdata));
  eeprom_table_model u_eep (.clk(clk), .rst(rst), .tableReq(tableReq),
    .tableWrite(tableWrite), .tableIndex(tableIndex), .tableWdata(tableWdata),
    .tableDone(tableDone), .tableRdata(tableRdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  // The wait loops end only when hready is high; the bench timeout, never a cycle count, bounds them.
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  task automatic poll(input logic v);
    logic [31:0] q;
    do bus(1'b0, 32'h5c, 32'h0, q); while (q[31] !== v);
  endtask
  task automatic do_reset(input logic up);
    @(posedge clk);
    isUpstream <= up;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_down_regs();
    rdc("msg control", 32'h4c, 32'h0080_6405);
    rdc("msg address", 32'h50, 32'h0);
    rdc("msg upper", 32'h54, 32'h0);
    rdc("msg payload", 32'h58, 32'h0);
    rdc("vendor header", 32'h64, 32'h0034_b009);
    wr(32'h5c, 32'hffff_ffff);
    rdc("absent ctrl", 32'h5c, 32'h0);
    rdc("absent data", 32'h60, 32'h0);
    wr(32'h50, 32'hffff_ffff);
    rdc("msg address", 32'h50, 32'hffff_fffc);
    wr(32'h54, 32'h1234_5678);
    rdc("msg upper", 32'h54, 32'h1234_5678);
    wr(32'h58, 32'hffff_ffff);
    rdc("msg payload", 32'h58, 32'h0000_ffff);
  endtask
  task automatic t_event(input logic msg);
    @(posedge clk) serviceEvent <= 1'b1;
    @(posedge clk) serviceEvent <= 1'b0;
    @(posedge clk) chk("legacy pin", {31'h0, ~msg}, {31'h0, legacyIntPin});
    @(posedge clk) chk("msg valid", {31'h0, msg}, {31'h0, msgWriteValid});
  endtask
  task automatic t_message();
    wr(32'h4c, 32'hff5f_ffff);
    rdc("msg control", 32'h4c, 32'h00d1_6405);
    t_event(1'b1);
    chk("msg addr hi", 32'h1234_5678, msgWriteAddr[63:32]);
    chk("msg addr lo", 32'hffff_fffc, msgWriteAddr[31:0]);
    chk("msg data", 32'hffff, {16'h0, msgWriteData});
    repeat (3) @(posedge clk);
    msgWriteReady <= 1'b1;
    @(posedge clk) msgWriteReady <= 1'b0;
    @(posedge clk) chk("msg done", 32'h0, {31'h0, msgWriteValid});
  endtask
  task automatic t_table();
    rdc("upstream msg", 32'h50, 32'h0);
    rdc("ctrl reset", 32'h5c, 32'h0000_6403);
    rdc("data reset", 32'h60, 32'h0);
    wr(32'h84, 32'h3);
    wr(32'h60, 32'ha5c3_3c5a);
    wr(32'h5c, 32'hc0fc_0000);
    poll(1'b0);
    rdc("ctrl written", 32'h5c, 32'h40fc_6403);
    chk("table word", 32'ha5c3_3c5a, u_eep.mem[63]);
    chk("irq write", 32'h1, {31'h0, irq});
    rdc("status", 32'h80, 32'h2);
    wr(32'h88, 32'h2);
    rdc("clear reads", 32'h88, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(32'h60, 32'h0);
    wr(32'h5c, 32'h00fc_0000);
    poll(1'b1);
    rdc("ctrl read", 32'h5c, 32'h80fc_6403);
    rdc("data read", 32'h60, 32'ha5c3_3c5a);
    chk("irq read", 32'h1, {31'h0, irq});
    wr(32'h84, 32'h0);
    rdc("unmapped", 32'h40, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask
  task automatic t_refused();
    logic [31:0] q;
    int          n;
    n = u_eep.reqCount;
    wr(32'h88, 32'h7);
    wr(32'h5c, 32'h80fc_0000);
    repeat (10) @(posedge clk);
    bus(1'b0, 32'h5c, 32'h0, q);
    chk("refused flag", 32'h0, {30'h0, q[31:30]});
    rdc("status", 32'h80, 32'h4);
    chk("no request", n, u_eep.reqCount);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    fail_count++;
    test_done();
  end
  initial begin
    {hsel, hwrite, serviceEvent, msgWriteReady, isUpstream} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_down_regs();
    t_event(1'b0);
    t_message();
    do_reset(1'b1);
    t_event(1'b0);
    t_table();
    t_refused();
    test_done();
  end
endmodule
